/* File: common/adcc_params.svh */
/*
 * Offsets, field positions, reset values and counts of the converter
 * control block. Assumes a 32-bit Wishbone slave with byte addresses.
 */
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// Register byte offsets
`define ADCC_OFF_CTRL_A   8'h00
`define ADCC_OFF_CTRL_B   8'h04
`define ADCC_OFF_RES_HI   8'h08
`define ADCC_OFF_RES_LO   8'h0c
`define ADCC_OFF_BANDGAP  8'h10
`define ADCC_OFF_IRQ      8'h14
`define ADCC_OFF_PINSEL   8'h18

// converter_control_a fields
`define ADCC_CA_START     7
`define ADCC_CA_BUSY      6
`define ADCC_CA_PWR       5
`define ADCC_CA_FMT       4
`define ADCC_CA_CH_LSB    0
// converter_control_b fields
`define ADCC_CB_SRC_LSB   5
`define ADCC_CB_REF_LSB   3
`define ADCC_CB_DIV_LSB   0
// bandgap_control, interrupt control fields
`define ADCC_BG_EN        0
`define ADCC_IRQ_GLB      0
`define ADCC_IRQ_EN       1
`define ADCC_IRQ_REQ      2

// Reset values
`define ADCC_CTRL_A_RST   8'h00
`define ADCC_CTRL_B_RST   8'h00
`define ADCC_BANDGAP_RST  8'h00
`define ADCC_IRQ_RST      3'h0

// Source and reference codes
`define ADCC_SRC_BANDGAP  3'h1
`define ADCC_SRC_AMP0     3'h2
`define ADCC_SRC_AMP1     3'h3
`define ADCC_SRC_LINE     3'h4
`define ADCC_REF_SUPPLY   2'h1

// Conversion timing in converter clocks
`define ADCC_SAMPLE_TICKS 4
`define ADCC_CONV_TICKS   12
`define ADCC_TOTAL_TICKS  16

`endif

/* File: common/adcc_pkg.sv */
/*
 * Types shared by the converter control modules.
 * Assumes adcc_params.svh supplies all numeric constants.
 */
package adcc_pkg;
    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcc_state_t;
    // Conversion result word
    typedef logic [11:0] adcc_result_t;
    // Register byte
    typedef logic [7:0]  adcc_byte_t;
endpackage

/* File: common/adcc_if.sv */
/*
 * Internal carrier between the control top, the clock divider and the
 * conversion sequencer. Assumes all ends share ref_clk.
 */
`timescale 1ns/1ps
interface adcc_core_if;
    import adcc_pkg::*;
    logic         startConv;   // Pulse: begin a conversion
    logic         abortConv;   // Level: converter powered down
    logic [2:0]   divSel;      // Clock divider code
    logic         tick;        // Pulse: one converter clock period
    logic         compIn;      // Comparator decision for current trial
    logic         finish;      // Pulse: last bit decided
    adcc_result_t finalResult; // Result valid with finish
    adcc_result_t trial;       // Trial code to the comparator
    logic         sampling;    // Level: sampling phase

    modport ctl (output startConv, abortConv, divSel, compIn,
                 input tick, finish, finalResult, trial, sampling);
    modport div (input startConv, divSel, output tick);
    modport seq (input startConv, abortConv, tick, compIn,
                 output finish, finalResult, trial, sampling);
endinterface

/* File: verilog/adcc_clkdiv.sv */
/*
 * Converter clock divider: one tick every 2^divSel system clocks.
 * Assumes the control top restarts it with startConv.
 */
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_clkdiv
(
    // Clock and reset
    input wire logic    ref_clk,
    input wire logic    rst_b,
    // Core carrier
    adcc_core_if.div    core
);
    import adcc_pkg::*;

    logic [6:0] cnt;      // Position inside the divided period
    logic [6:0] next_cnt;
    logic [6:0] limit;    // Last count of a period

    // Period limit and tick
    assign limit = 7'((8'h01 << core.divSel) - 8'h01);
    assign core.tick = (cnt == limit);

    // Next count: restart on start, wrap at limit
    always_comb
    begin
        if (core.startConv || cnt == limit)
            next_cnt = 7'h00;
        else
            next_cnt = cnt + 7'h01;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt <= 7'h00;
        else
            cnt <= next_cnt;
    end

    // Divide by two never ticks twice in a row
    a_div_two_gap: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (core.divSel == 3'h1 && core.tick && !core.startConv) |=> !core.tick)
        else $error("divide by two ticked on consecutive cycles");
endmodule // adcc_clkdiv

/* File: verilog/adcc_seq.sv */
/*
 * Conversion sequencer: sampling ticks, then one SAR bit per tick.
 * Assumes compIn is high when the input is at or above the trial code.
 */
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_seq
(
    // Clock and reset
    input wire logic    ref_clk,
    input wire logic    rst_b,
    // Core carrier
    adcc_core_if.seq    core
);
    import adcc_pkg::*;

    adcc_state_t  state, next_state;     // Phase
    logic [3:0]   cnt, next_cnt;         // Sample tick or bit index
    adcc_result_t trial, next_trial;     // SAR working code
    adcc_result_t mask;                  // Bit under trial
    adcc_result_t resolved;              // Trial with bit decided
    logic [4:0]   tickSeen;              // Helper: ticks since start

    assign mask = 12'h001 << cnt;
    assign resolved = core.compIn ? trial : (trial & ~mask);
    assign core.finish = (state == ST_CONVERT) && core.tick
        && (cnt == 4'h0) && !core.startConv;
    assign core.finalResult = resolved;
    assign core.trial = trial;
    assign core.sampling = (state == ST_SAMPLE);

    // Next phase, counter and trial code
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        next_trial = trial;
        if (core.abortConv)
            next_state = ST_IDLE;
        else if (core.startConv)
        begin
            next_state = ST_SAMPLE;
            next_cnt   = 4'h0;
            next_trial = 12'h000;
        end
        else if (core.tick)
        begin
            case (state)
                ST_SAMPLE:   // Four sampling periods
                begin
                    if (cnt == 4'(`ADCC_SAMPLE_TICKS - 1))
                    begin
                        next_state = ST_CONVERT;
                        next_cnt   = 4'(`ADCC_CONV_TICKS - 1);
                        next_trial = 12'h800;
                    end
                    else
                        next_cnt = cnt + 4'h1;
                end
                ST_CONVERT:  // One bit per period, MSB first
                begin
                    if (cnt == 4'h0)
                        next_state = ST_IDLE;
                    else
                    begin
                        next_cnt   = cnt - 4'h1;
                        next_trial = resolved | (mask >> 1);
                    end
                end
                default:
                    next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_IDLE;
            cnt   <= 4'h0;
            trial <= 12'h000;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
            trial <= next_trial;
        end
    end

    // Helper tick counter for the length check
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            tickSeen <= 5'h00;
        else if (core.startConv)
            tickSeen <= 5'h00;
        else if (core.tick && state != ST_IDLE)
            tickSeen <= tickSeen + 5'h01;
    end

    a_conv_length: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        core.finish |-> tickSeen == 5'(`ADCC_TOTAL_TICKS - 1))
        else $error("conversion did not take sixteen clocks");
endmodule // adcc_seq

/* File: verilog/adcc_top.sv */
/*
 * Converter input selection and conversion control top.
 * Holds the Wishbone register file, input routing, pin override,
 * start detection, busy, result bytes and completion request.
 * Assumes a classic Wishbone master on ref_clk and an analog SAR
 * core that returns a comparator decision for the trial code.
 */
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_top
#(
    parameter int NUM_PINS = 8
)
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output      logic [31:0]           wb_dat_o,
    output      logic                  wb_ack_o,
    // Analog core
    input  wire logic                  compIn,
    output      logic                  converterPowerOn,
    output      logic                  sampleActive,
    output      adcc_pkg::adcc_result_t sarTrial,
    output      logic [NUM_PINS-1:0]   extChanSel,
    output      logic [3:0]            intSrcSel,
    output      logic                  refFromSupply,
    output      logic                  bandgapOn,
    // Shared pins
    input  wire logic [NUM_PINS-1:0]   portDirOut,
    input  wire logic [NUM_PINS-1:0]   pullupReq,
    output      logic [NUM_PINS-1:0]   pinAnalogMode,
    output      logic [NUM_PINS-1:0]   pinDigitalOn,
    output      logic [NUM_PINS-1:0]   pinPullupOn,
    output      logic [NUM_PINS-1:0]   pinOutEn_b,
    // Completion interrupt
    output      logic                  adcIrq
);
    import adcc_pkg::*;

    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    adcc_core_if core();                    // Carrier to submodules

    adcc_byte_t          ctrlA, next_ctrlA; // converter_control_a
    adcc_byte_t          ctrlB, next_ctrlB; // converter_control_b
    adcc_byte_t          bgCtrl, next_bgCtrl; // bandgap_control
    logic [2:0]          irqCtrl, next_irqCtrl; // Enables and request
    logic [NUM_PINS-1:0] pinSel, next_pinSel; // Analog function select
    adcc_byte_t          resHi, next_resHi; // result_high_byte
    adcc_byte_t          resLo, next_resLo; // result_low_byte
    logic                busy, next_busy;   // conversion_busy_flag
    logic                startConv, next_startConv; // Start pulse
    logic                ack, next_ack;     // Bus answer
    logic [31:0]         rdData, next_rdData; // Read data
    logic                wrEn;              // Write taken this edge
    logic                startFall;         // Start pulse completes
    logic [2:0]          srcSel;            // source_select
    logic [3:0]          chanSel;           // channel_select
    logic                pwrOn;             // converter_power_enable

    logic [NUM_PINS-1:0] next_extChanSel;
    logic [3:0]          next_intSrcSel;
    logic [NUM_PINS-1:0] next_pinDigitalOn;
    logic [NUM_PINS-1:0] next_pinPullupOn;
    logic [NUM_PINS-1:0] next_pinOutEn_b;
    logic                next_adcIrq;

    assign srcSel  = ctrlB[`ADCC_CB_SRC_LSB +: 3];
    assign chanSel = ctrlA[`ADCC_CA_CH_LSB +: 4];
    assign pwrOn   = ctrlA[`ADCC_CA_PWR];

    //------------------------------------------------------------------
    // Submodules
    //------------------------------------------------------------------
    assign core.startConv = startConv;
    assign core.abortConv = !pwrOn;
    assign core.divSel    = ctrlB[`ADCC_CB_DIV_LSB +: 3];
    assign core.compIn    = compIn;

    adcc_clkdiv u_div
    (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .core    (core.div)
    );

    adcc_seq u_seq
    (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .core    (core.seq)
    );

    //------------------------------------------------------------------
    // Register file and conversion control
    //------------------------------------------------------------------
    // Write takes effect on the edge that raises ack
    assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && !ack && wb_sel_i[0];
    // Start clears from one to zero while powered
    assign startFall = wrEn && wb_adr_i == `ADCC_OFF_CTRL_A && pwrOn
        && wb_dat_i[`ADCC_CA_PWR] && ctrlA[`ADCC_CA_START]
        && !wb_dat_i[`ADCC_CA_START];

    // Next register contents
    always_comb
    begin
        next_ctrlA     = ctrlA;
        next_ctrlB     = ctrlB;
        next_bgCtrl    = bgCtrl;
        next_irqCtrl   = irqCtrl;
        next_pinSel    = pinSel;
        next_resHi     = resHi;
        next_resLo     = resLo;
        next_busy      = busy;
        next_startConv = startFall;
        next_ack       = wb_cyc_i && wb_stb_i && !ack;
        if (wrEn)
        begin
            case (wb_adr_i)
                `ADCC_OFF_CTRL_A:  // Busy bit is read-only
                begin
                    next_ctrlA = wb_dat_i[7:0];
                    next_ctrlA[`ADCC_CA_BUSY] = 1'b0;
                end
                `ADCC_OFF_CTRL_B:  next_ctrlB = wb_dat_i[7:0];
                `ADCC_OFF_BANDGAP: // Only the enable bit exists
                    next_bgCtrl = {7'h00, wb_dat_i[`ADCC_BG_EN]};
                `ADCC_OFF_IRQ:     next_irqCtrl = wb_dat_i[2:0];
                `ADCC_OFF_PINSEL:  next_pinSel = wb_dat_i[NUM_PINS-1:0];
                default:           next_ctrlA = ctrlA;
            endcase
        end
        // Completion: results, request, busy in one cycle
        if (core.finish && pwrOn)
        begin
            next_busy = 1'b0;
            next_irqCtrl[`ADCC_IRQ_REQ] = 1'b1;
            if (ctrlA[`ADCC_CA_FMT])
            begin
                next_resHi = {4'h0, core.finalResult[11:8]};
                next_resLo = core.finalResult[7:0];
            end
            else
            begin
                next_resHi = core.finalResult[11:4];
                next_resLo = {core.finalResult[3:0], 4'h0};
            end
        end
        if (!next_ctrlA[`ADCC_CA_PWR])
            next_busy = 1'b0;
        if (startFall)
            next_busy = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrlA     <= `ADCC_CTRL_A_RST;
            ctrlB     <= `ADCC_CTRL_B_RST;
            bgCtrl    <= `ADCC_BANDGAP_RST;
            irqCtrl   <= `ADCC_IRQ_RST;
            pinSel    <= '0;
            resHi     <= 8'h00;
            resLo     <= 8'h00;
            busy      <= 1'b0;
            startConv <= 1'b0;
            ack       <= 1'b0;
        end
        else
        begin
            ctrlA     <= next_ctrlA;
            ctrlB     <= next_ctrlB;
            bgCtrl    <= next_bgCtrl;
            irqCtrl   <= next_irqCtrl;
            pinSel    <= next_pinSel;
            resHi     <= next_resHi;
            resLo     <= next_resLo;
            busy      <= next_busy;
            startConv <= next_startConv;
            ack       <= next_ack;
        end
    end

    //------------------------------------------------------------------
    // Read data
    //------------------------------------------------------------------
    // Registered read mux, unmapped reads give zero
    always_comb
    begin
        next_rdData = 32'h0000_0000;
        case (wb_adr_i)
            `ADCC_OFF_CTRL_A:
            begin
                next_rdData[7:0] = ctrlA;
                next_rdData[`ADCC_CA_BUSY] = busy;
            end
            `ADCC_OFF_CTRL_B:  next_rdData[7:0] = ctrlB;
            `ADCC_OFF_RES_HI:  next_rdData[7:0] = resHi;
            `ADCC_OFF_RES_LO:  next_rdData[7:0] = resLo;
            `ADCC_OFF_BANDGAP: next_rdData[7:0] = bgCtrl;
            `ADCC_OFF_IRQ:     next_rdData[2:0] = irqCtrl;
            `ADCC_OFF_PINSEL:  next_rdData[NUM_PINS-1:0] = pinSel;
            default:           next_rdData = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdData <= 32'h0000_0000;
        else
            rdData <= next_rdData;
    end

    assign wb_dat_o = rdData;
    assign wb_ack_o = ack;
    assign sarTrial = core.trial;

    //------------------------------------------------------------------
    // Input routing, pin override and interrupt output
    //------------------------------------------------------------------
    // Routing and pin state computed from the registers
    always_comb
    begin
        next_extChanSel = '0;
        // Channels 8-15 leave every pin disconnected
        if (!chanSel[3] && chanSel[2:0] < NUM_PINS)
            next_extChanSel[chanSel[2:0]] = 1'b1;
        next_intSrcSel = {srcSel == `ADCC_SRC_LINE,
                          srcSel == `ADCC_SRC_AMP1,
                          srcSel == `ADCC_SRC_AMP0,
                          srcSel == `ADCC_SRC_BANDGAP};
        next_pinDigitalOn = ~pinSel;
        next_pinPullupOn  = pullupReq & ~pinSel;
        next_pinOutEn_b   = ~(portDirOut & ~pinSel);
        next_adcIrq = irqCtrl[`ADCC_IRQ_REQ] && irqCtrl[`ADCC_IRQ_GLB]
            && irqCtrl[`ADCC_IRQ_EN];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            extChanSel       <= '0;
            intSrcSel        <= 4'h0;
            refFromSupply    <= 1'b0;
            bandgapOn        <= 1'b0;
            converterPowerOn <= 1'b0;
            pinAnalogMode    <= '0;
            pinDigitalOn     <= '1;
            pinPullupOn      <= '0;
            pinOutEn_b       <= '1;
            adcIrq           <= 1'b0;
            sampleActive     <= 1'b0;
        end
        else
        begin
            extChanSel       <= next_extChanSel;
            intSrcSel        <= next_intSrcSel;
            refFromSupply    <= ctrlB[`ADCC_CB_REF_LSB +: 2]
                                == `ADCC_REF_SUPPLY;
            bandgapOn        <= bgCtrl[`ADCC_BG_EN];
            converterPowerOn <= pwrOn;
            pinAnalogMode    <= pinSel;
            pinDigitalOn     <= next_pinDigitalOn;
            pinPullupOn      <= next_pinPullupOn;
            pinOutEn_b       <= next_pinOutEn_b;
            adcIrq           <= next_adcIrq;
            sampleActive     <= core.sampling;
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb_chk @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    a_busy_on_start: assert property (
        startFall |=> busy ##1 startConv == 1'b0)
        else $error("busy did not rise with the start pulse");
    a_finish_clears: assert property (
        (core.finish && !startFall && pwrOn) |=>
            !busy && irqCtrl[`ADCC_IRQ_REQ])
        else $error("completion did not clear busy and set request");
    a_result_format: assert property (
        (core.finish && pwrOn && !ctrlA[`ADCC_CA_FMT]) |=>
            resHi == $past(core.finalResult[11:4]) && resLo[3:0] == 4'h0)
        else $error("result bytes not left aligned");
    a_ext_floating: assert property (
        chanSel[3] |=> extChanSel == '0)
        else $error("pin routed for a non-existent channel");
    a_int_bandgap: assert property (
        srcSel == `ADCC_SRC_BANDGAP |=> intSrcSel == 4'h1)
        else $error("bandgap source not routed");
    a_pullup_off: assert property (
        ##1 (pinPullupOn & $past(pinSel)) == '0)
        else $error("pull-high left on an analog pin");
    a_dir_ignored: assert property (
        ##1 (~pinOutEn_b & $past(pinSel)) == '0
            && (pinDigitalOn & $past(pinSel)) == '0)
        else $error("analog pin still driven or digital");
    a_power_off: assert property (
        !pwrOn |=> !busy && !converterPowerOn)
        else $error("converter active while powered down");
    a_ref_supply: assert property (
        ctrlB[`ADCC_CB_REF_LSB +: 2] != `ADCC_REF_SUPPLY |=> !refFromSupply)
        else $error("supply reference taken for wrong code");
endmodule // adcc_top

/* File: dv/adcc_top_test.sv */
/* Self-checking bench of adcc_top: register table, input routing,
   pin override, conversion timing, result bytes and completion request.
   Assumes adcc_pkg and adcc_params.svh are compiled first. */
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_top_test;
    import adcc_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic         ref_clk = 0, rst_b = 0, cyc = 0, we = 0;
    logic [7:0]   adr = 0, portDir = 0, pull = 0;
    logic [31:0]  wdat = 0, rdat, datO;
    logic         ack, pwr, smp, bg, refS, irq;
    logic [7:0]   ext, aMode, dOn, puOn, oeB;
    logic [3:0]   src;
    adcc_result_t trial;
    int           failures = 0, samples_checked = 0, clkN = 0, smpN = 0;
    logic [37:0]  rows [12] = '{ // Adr, wdata, rdata, route
        {8'h00,8'h23,8'h23,14'h0200}, {8'h00,8'h28,8'h28,14'h0000},
        {8'h04,8'h20,8'h20,14'h0004}, {8'h04,8'h40,8'h40,14'h0008},
        {8'h04,8'h60,8'h60,14'h0010}, {8'h04,8'h80,8'h80,14'h0020},
        {8'h04,8'ha0,8'ha0,14'h0000}, {8'h04,8'h08,8'h08,14'h0002},
        {8'h04,8'h18,8'h18,14'h0000}, {8'h10,8'hff,8'h01,14'h0001},
        {8'h00,8'h27,8'h27,14'h2001}, {8'h1c,8'hff,8'h00,14'h2001}};
    // Comparator model: input level fixed at 0xa5c
    wire          compIn = (trial <= 12'ha5c);
    always #2.5 ref_clk = ~ref_clk;
    // Free cycle and sampling-phase counters
    always @(posedge ref_clk) clkN <= clkN + 1;
    always @(posedge ref_clk) smpN <= smpN + (smp === 1'b1);
    adcc_top DUT (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack), .compIn(compIn),
        .converterPowerOn(pwr), .sampleActive(smp), .sarTrial(trial),
        .extChanSel(ext), .intSrcSel(src), .refFromSupply(refS),
        .bandgapOn(bg), .portDirOut(portDir), .pullupReq(pull),
        .pinAnalogMode(aMode), .pinDigitalOn(dOn), .pinPullupOn(puOn),
        .pinOutEn_b(oeB), .adcIrq(irq));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(logic w, logic [7:0] a, logic [7:0] d);
        int n;
        @(posedge ref_clk);
        cyc <= 1; we <= w; adr <= a; wdat <= {24'h0, d};
        n = 0;
        do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin failures++; test_done(); end
        rdat = datO;
        cyc <= 0; we <= 0;
    endtask
    task automatic rd(string nm, logic [7:0] a, logic [7:0] e);
        wb(0, a, 8'h00);
        chk(nm, {24'h0, e}, rdat);
    endtask
    // One conversion: divider, start pulse, timing, bytes, request
    task automatic conv(logic [7:0] ca, logic [2:0] dv, logic [7:0] hi, lo);
        int t0, s0, p;
        p = 1 << dv;
        wb(1, `ADCC_OFF_CTRL_B, {5'h0, dv});
        wb(1, `ADCC_OFF_CTRL_A, ca | 8'h80);
        wb(1, `ADCC_OFF_CTRL_A, ca);
        t0 = clkN; s0 = smpN;
        rd("busy", `ADCC_OFF_CTRL_A, ca | 8'h40);
        chk("pwrOn", 1, pwr);
        while (irq !== 1'b1 && clkN - t0 < 3000) @(posedge ref_clk);
        if (irq !== 1'b1) begin failures++; test_done(); end
        t0 = clkN - t0;
        s0 = smpN - s0;
        chk("time", 1, t0 >= 16*p && t0 <= 16*p + 4);
        chk("sample", 1, s0 >= 4*p && s0 <= 4*p + 1);
        rd("idle", `ADCC_OFF_CTRL_A, ca);
        rd("hi", `ADCC_OFF_RES_HI, hi);
        rd("lo", `ADCC_OFF_RES_LO, lo);
        rd("req", `ADCC_OFF_IRQ, 8'h07);
        wb(1, `ADCC_OFF_IRQ, 8'h03);
        rd("clr", `ADCC_OFF_IRQ, 8'h03);
        chk("irq", 0, irq);
        $display("conversion with divider %0d done", dv);
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1;
        chk("oeB", 8'hff, oeB);
        rd("ctrlA", `ADCC_OFF_CTRL_A, `ADCC_CTRL_A_RST);
        rd("bgap", `ADCC_OFF_BANDGAP, `ADCC_BANDGAP_RST);
        $display("reset test done");
        foreach (rows[i])
        begin
            wb(1, rows[i][37:30], rows[i][29:22]);
            rd("rdback", rows[i][37:30], rows[i][21:14]);
            chk("ext", rows[i][13:6], ext);
            chk("rt", rows[i][5:0], {src,refS,bg});
        end
        $display("register rows done");
        portDir <= 8'hff;
        pull <= 8'hff;
        wb(1, `ADCC_OFF_PINSEL, 8'h05);
        rd("pinsel", `ADCC_OFF_PINSEL, 8'h05);
        chk("dig", 16'h05fa, {aMode, dOn});
        chk("pull", 8'hfa, puOn);
        chk("dir", 8'h05, oeB);
        $display("pin test done");
        wb(1, `ADCC_OFF_IRQ, 8'h03);
        conv(8'h21, 3'h0, 8'ha5, 8'hc0);
        conv(8'h21, 3'h1, 8'ha5, 8'hc0);
        conv(8'h31, 3'h2, 8'h0a, 8'h5c);
        wb(1, `ADCC_OFF_CTRL_A, 8'ha0);
        wb(1, `ADCC_OFF_CTRL_A, 8'h20);
        wb(1, `ADCC_OFF_CTRL_A, 8'h00);
        repeat (40) @(posedge ref_clk);
        chk("pwr", 0, {pwr, irq});
        rd("abort", `ADCC_OFF_IRQ, 8'h03);
        rd("abortBusy", `ADCC_OFF_CTRL_A, 8'h00);
        $display("abort test done");
        rst_b <= 0;
        @(posedge ref_clk);
        chk("rstOe", 8'hff, oeB);
        rst_b <= 1;
        rd("rstPin", `ADCC_OFF_PINSEL, 8'h00);
        rd("rstIrq", `ADCC_OFF_IRQ, `ADCC_IRQ_RST);
        $display("mid-run reset test done");
        test_done();
    end
endmodule // adcc_top_test
